// ==== hdl/cupt_regs.svh ====
/*
  Register indices, byte addresses, field positions, reset values and
  timing counts of the clock unit periodic timer block.
  Assumes a 32-bit APB with one aligned word per register; the byte
  address of a register is four times its index.
*/
`ifndef CUPT_REGS_SVH
`define CUPT_REGS_SVH

// ==========================================================================
// Register indices and byte addresses
// ==========================================================================
`define CUPT_IDX_STATUS     12'h037
`define CUPT_IDX_CLK_CTRL   12'h038
`define CUPT_IDX_PLL_CFG    12'h03A
`define CUPT_IDX_RTI        12'h03B
`define CUPT_IDX_IRQ_STAT   12'h040
`define CUPT_IDX_IRQ_CLR    12'h041
`define CUPT_IDX_IRQ_EN     12'h042
`define CUPT_IDX_API_CTRL   12'h2F2
`define CUPT_IDX_API_RATE_H 12'h2F4
`define CUPT_IDX_API_RATE_L 12'h2F5

`define CUPT_ADDR_STATUS     12'h0DC
`define CUPT_ADDR_CLK_CTRL   12'h0E0
`define CUPT_ADDR_PLL_CFG    12'h0E8
`define CUPT_ADDR_RTI        12'h0EC
`define CUPT_ADDR_IRQ_STAT   12'h100
`define CUPT_ADDR_IRQ_CLR    12'h104
`define CUPT_ADDR_IRQ_EN     12'h108
`define CUPT_ADDR_API_CTRL   12'hBC8
`define CUPT_ADDR_API_RATE_H 12'hBD0
`define CUPT_ADDR_API_RATE_L 12'hBD4

// ==========================================================================
// Field positions
// ==========================================================================
`define CUPT_PLL_MOD_HI      5
`define CUPT_PLL_MOD_LO      4
`define CUPT_CLK_SRC_SEL     0
`define CUPT_CLK_PSEUDO_STOP_SEL        1
`define CUPT_CLK_OSC_CHANGE_IRQ_EN       2
`define CUPT_API_FE          0
`define CUPT_API_CLKSEL      1
`define CUPT_STAT_LOCK       0
`define CUPT_STAT_OSCQ       1
`define CUPT_IRQ_RTI         0
`define CUPT_IRQ_API         1
`define CUPT_IRQ_OSC         2
`define CUPT_RTI_DEC         7

// ==========================================================================
// Reset values and timing counts
// ==========================================================================
`define CUPT_RST_BYTE        8'h00
`define CUPT_RST_IRQ         3'h0
`define CUPT_FM_DIV          4'hF
`define CUPT_RTI_DEC_BASE    24'h00_03E8
`define CUPT_RTI_BIN_SHIFT   5'h09

`endif

// ==== hdl/cupt_pkg.sv ====
/*
  Types of the clock unit periodic timer block: the APB request carrier
  the timer clock select and the state record of cupt_clock_unit.
  Assumes cupt_regs.svh is on the include path.
*/
package cupt_pkg;

  // ========================================================================
  // Bus carrier
  // ========================================================================
  typedef struct packed {
    logic        psel;     // Slave selected
    logic        penable;  // Access phase
    logic        pwrite;   // Write when high
    logic [11:0] paddr;    // Byte address
    logic [31:0] pwdata;   // Write data
  } cupt_apb_req_t;

  // Clock chosen for the periodic timer
  typedef enum logic {
    CUPT_API_ACLK,
    CUPT_API_BUSCLK
  } cupt_api_clk_t;

  // ========================================================================
  // Main state record
  // ========================================================================
  typedef struct packed {
    logic [7:0]  pll_cfg;       // PLL configuration byte
    logic        lock_flag;     // PLL lock status
    logic        osc_flag;      // Oscillator qualified status
    logic        src_sel;       // Timer source select
    logic        pseudo_stop_sel;          // Pseudo-stop select
    logic        osc_change_irq_en;         // Oscillator change interrupt enable
    logic [7:0]  rti_ctrl;      // Timeout rate control
    logic [23:0] rti_cnt;       // Timeout down counter
    logic        rti_src_q;     // Effective source last cycle
    logic [15:0] api_rate;      // Periodic rate value
    logic        api_en;        // Periodic feature enable
    logic        api_clk;       // Periodic clock select
    logic [3:0]  fm_div;        // Modulation rate prescaler
    logic        fm_dir;        // Modulation sweep direction
    logic        fm_tick;       // Modulation rate pulse
    logic [2:0]  irq_stat;      // Sticky event flags
    logic [2:0]  irq_en;        // Event enables
    logic [31:0] prdata;        // Read data
    logic        pslverr;       // Error answer
  } cupt_state_t;

endpackage : cupt_pkg

// ==== hdl/cupt_sync.sv ====
/*
  Two-flop synchroniser for a group of pin levels with a registered
  rising-edge pulse per bit.
  Assumes the inputs are asynchronous to clk_sys_i.
*/
module cupt_sync
  import cupt_pkg::*;
#(
  parameter int W = 1  // Number of bits
) (
  input  wire logic         clk_sys_i,  // System clock
  input  wire logic         srst_i,     // Synchronous reset
  input  wire logic [W-1:0] async_i,    // Raw pin levels
  output logic      [W-1:0] level_o,    // Synchronised levels
  output logic      [W-1:0] rise_o      // One-cycle rising pulses
);

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    logic [W-1:0] meta;    // First stage, read only by the second
    logic [W-1:0] stable;  // Second stage
    logic [W-1:0] prev;    // Delayed copy for edge detection
    logic [W-1:0] rise;    // Edge pulse
  } cupt_sync_st_t;

  cupt_sync_st_t st;
  cupt_sync_st_t next_st;

  // Next state: edge taken from stable stages only
  always_comb begin
    next_st        = st;
    next_st.meta   = async_i;
    next_st.stable = st.meta;
    next_st.prev   = st.stable;
    next_st.rise   = st.stable & ~st.prev;
  end

  // Register the record
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.stable;
  assign rise_o  = st.rise;

endmodule : cupt_sync

// ==== hdl/cupt_api_timer.sv ====
/*
  Autonomous periodic timer: counts 2*(rate+1) ticks of the chosen clock
  and pulses a timeout at the end of every period.
  Assumes the rate is stable while the timer is enabled.
*/
module cupt_api_timer
  import cupt_pkg::*;
(
  input  wire logic          clk_sys_i,   // System clock
  input  wire logic          srst_i,      // Synchronous reset
  input  wire logic          en_i,        // Feature enable
  input  cupt_api_clk_t      clk_sel_i,   // Clock select
  input  wire logic          aclk_tick_i, // Autonomous clock pulse
  input  wire logic [15:0]   rate_i,      // Rate value
  output logic               timeout_o    // One-cycle timeout pulse
);

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    logic [16:0] cnt;      // Down counter, 2*rate+1 to 0
    logic        timeout;  // Timeout pulse
  } cupt_api_st_t;

  cupt_api_st_t st;
  cupt_api_st_t next_st;
  logic         tick;      // Counting step

  // Bus clock counts every cycle, the autonomous one on its pulses
  assign tick = (clk_sel_i == CUPT_API_BUSCLK) ? 1'b1 : aclk_tick_i;

  // Next state
  always_comb begin
    next_st         = st;
    next_st.timeout = 1'b0;
    if (!en_i) begin
      // Held at full load so the first period is whole
      next_st.cnt = {rate_i, 1'b1};
    end else if (tick) begin
      if (st.cnt == 17'h0_0000) begin
        next_st.timeout = 1'b1;
        next_st.cnt     = {rate_i, 1'b1};
      end else begin
        next_st.cnt = st.cnt - 17'h0_0001;
      end
    end
  end

  // Register the record
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign timeout_o = st.timeout;

endmodule : cupt_api_timer

// ==== hdl/cupt_clock_unit.sv ====
/*
  Clock unit periodic timers: PLL modulation control, real-time timeout
  counter, autonomous periodic timer, oscillator status and interrupts,
  all reached over APB.
  Assumes clock pins and status pins are asynchronous and are sampled
  through two flops; the PLL itself sits outside and reads the
  modulation outputs.
*/
`include "cupt_regs.svh"

// Functional notes
// - Modulate PLL when enabled, rate ref/16
// - Modulation code: off, 1%, 2%, 4%
// - PLL config write clears lock, qualified
// - Timeout counter from reference or oscillator
// - Stop halts counter unless pseudo-stop, oscillator
// - Timeout control register, reset zero, RW
// - Control write restarts timeout period
// - Source change restarts timeout period
// - Rate writes ignored while periodic enabled
// - Autonomous period is 2*(rate+1) ticks
// - Bus clock period is 2*(rate+1) cycles
// - Rate low byte, reset zero
// - PLL change or lock loss clears qualified
// - Oscillator interrupt only when enabled
module cupt_clock_unit
  import cupt_pkg::*;
(
  input  wire logic          clk_sys_i,          // System clock, 50 MHz
  input  wire logic          srst_i,             // Synchronous reset
  input  cupt_apb_req_t      apb_i,              // APB request
  output logic               pready_o,           // APB ready
  output logic [31:0]        prdata_o,           // APB read data
  output logic               pslverr_o,          // APB error
  input  wire logic          internal_ref_clk_i, // Reference clock pin
  input  wire logic          crystal_osc_clk_i,  // Oscillator clock pin
  input  wire logic          aclk_i,             // Autonomous clock pin
  input  wire logic          pll_lock_i,         // PLL lock detector
  input  wire logic          osc_filter_ok_i,    // Oscillator filter good
  input  wire logic          stop_mode_i,        // Stop mode request
  output logic [1:0]         fm_amp_o,           // Modulation amplitude
  output logic               fm_rate_tick_o,     // Modulation rate pulse
  output logic               fm_dir_o,           // Modulation sweep direction
  output logic               irq_o               // Interrupt, active high
);

  // ========================================================================
  // Synchronised inputs
  // ========================================================================
  logic [5:0] pin_level;   // Synchronised pin levels
  logic [5:0] pin_rise;    // Rising edges of them
  logic       ref_tick;    // Reference clock pulse
  logic       osc_tick;    // Oscillator clock pulse
  logic       aclk_tick;   // Autonomous clock pulse
  logic       lock_lvl;    // PLL locked
  logic       filt_lvl;    // Oscillator filter good
  logic       stop_lvl;    // In stop mode

  // All pins pass two flops before any logic reads them
  cupt_sync #(
    .W (6)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .async_i   ({stop_mode_i, osc_filter_ok_i, pll_lock_i,
                 aclk_i, crystal_osc_clk_i, internal_ref_clk_i}),
    .level_o   (pin_level),
    .rise_o    (pin_rise)
  );

  assign ref_tick  = pin_rise[0];
  assign osc_tick  = pin_rise[1];
  assign aclk_tick = pin_rise[2];
  assign lock_lvl  = pin_level[3];
  assign filt_lvl  = pin_level[4];
  assign stop_lvl  = pin_level[5];

  // ========================================================================
  // State and bus decode
  // ========================================================================
  cupt_state_t st;       // All registered state
  cupt_state_t next_st;  // Next value of it
  logic        api_timeout;  // Periodic timer pulse
  logic        setup;        // APB setup phase
  logic        wr_acc;       // APB write taking effect
  logic [11:0] wr_addr;      // Address of that write
  logic [7:0]  wr_byte;      // Low byte of write data

  assign setup   = apb_i.psel & ~apb_i.penable;
  assign wr_acc  = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign wr_addr = apb_i.paddr;
  assign wr_byte = apb_i.pwdata[7:0];

  // Whether an address belongs to a register
  function automatic logic addr_mapped(input logic [11:0] a);
    unique case (a)
      `CUPT_ADDR_STATUS, `CUPT_ADDR_CLK_CTRL, `CUPT_ADDR_PLL_CFG,
      `CUPT_ADDR_RTI, `CUPT_ADDR_IRQ_STAT, `CUPT_ADDR_IRQ_CLR,
      `CUPT_ADDR_IRQ_EN, `CUPT_ADDR_API_CTRL, `CUPT_ADDR_API_RATE_H,
      `CUPT_ADDR_API_RATE_L: addr_mapped = 1'b1;
      default:               addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // Read value of a register; write-only and unmapped read zero
  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input cupt_state_t s);
    read_word = 32'h0000_0000;
    unique case (a)
      `CUPT_ADDR_STATUS:     read_word[1:0] = {s.osc_flag, s.lock_flag};
      `CUPT_ADDR_CLK_CTRL:   read_word[2:0] = {s.osc_change_irq_en, s.pseudo_stop_sel, s.src_sel};
      `CUPT_ADDR_PLL_CFG:    read_word[7:0] = s.pll_cfg;
      `CUPT_ADDR_RTI:        read_word[7:0] = s.rti_ctrl;
      `CUPT_ADDR_IRQ_STAT:   read_word[2:0] = s.irq_stat;
      `CUPT_ADDR_IRQ_EN:     read_word[2:0] = s.irq_en;
      `CUPT_ADDR_API_CTRL:   read_word[1:0] = {s.api_clk, s.api_en};
      `CUPT_ADDR_API_RATE_H: read_word[7:0] = s.api_rate[15:8];
      `CUPT_ADDR_API_RATE_L: read_word[7:0] = s.api_rate[7:0];
      default:               read_word      = 32'h0000_0000;
    endcase
  endfunction : read_word

  // Timeout period in source ticks; zero means the counter is off.
  // Binary: (low nibble+1) shifted by 9 plus prescaler; decimal: multiples of
  // a thousand. Prescaler zero in binary mode stops the counter.
  function automatic logic [23:0] rti_period(input logic [7:0] c);
    logic [23:0] base;
    base = {20'h0_0000, c[3:0]} + 24'h00_0001;
    if (c[`CUPT_RTI_DEC]) begin
      rti_period = (base * `CUPT_RTI_DEC_BASE) << c[6:4];
    end else if (c[6:4] == 3'h0) begin
      rti_period = 24'h00_0000;
    end else begin
      rti_period = base << (`CUPT_RTI_BIN_SHIFT + {2'h0, c[6:4]});
    end
  endfunction : rti_period

  // ========================================================================
  // Periodic timer
  // ========================================================================
  cupt_api_timer u_api (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .en_i        (st.api_en),
    .clk_sel_i   (cupt_api_clk_t'(st.api_clk)),
    .aclk_tick_i (aclk_tick),
    .rate_i      (st.api_rate),
    .timeout_o   (api_timeout)
  );

  // ========================================================================
  // Next state
  // ========================================================================
  logic        pll_wr;      // Write to PLL configuration
  logic        rti_src;     // Effective timeout source, 1 = oscillator
  logic        rti_tick;    // Timeout counting step
  logic        rti_run;     // Timeout counter may run
  logic        rti_restart; // Reload the timeout period
  logic        rti_event;   // Timeout reached
  logic        osc_change;  // Qualified status changed
  logic [2:0]  irq_set;     // Events this cycle

  always_comb begin
    next_st     = st;
    pll_wr      = wr_acc && (wr_addr == `CUPT_ADDR_PLL_CFG);
    rti_event   = 1'b0;

    // Control and configuration writes
    if (wr_acc) begin
      unique case (wr_addr)
        `CUPT_ADDR_CLK_CTRL: begin
          next_st.src_sel = wr_byte[`CUPT_CLK_SRC_SEL];
          next_st.pseudo_stop_sel    = wr_byte[`CUPT_CLK_PSEUDO_STOP_SEL];
          next_st.osc_change_irq_en   = wr_byte[`CUPT_CLK_OSC_CHANGE_IRQ_EN];
        end
        `CUPT_ADDR_PLL_CFG:  next_st.pll_cfg  = wr_byte;
        `CUPT_ADDR_RTI:      next_st.rti_ctrl = wr_byte;
        `CUPT_ADDR_IRQ_EN:   next_st.irq_en   = wr_byte[2:0];
        `CUPT_ADDR_API_CTRL: begin
          next_st.api_en  = wr_byte[`CUPT_API_FE];
          next_st.api_clk = wr_byte[`CUPT_API_CLKSEL];
        end
        `CUPT_ADDR_API_RATE_H: begin
          if (!st.api_en) begin
            next_st.api_rate[15:8] = wr_byte;
          end
        end
        `CUPT_ADDR_API_RATE_L: begin
          if (!st.api_en) begin
            next_st.api_rate[7:0] = wr_byte;
          end
        end
        default: begin
          // Status, clear and unmapped words store nothing
        end
      endcase
    end

    // Lock follows the detector; a configuration write drops it at once
    next_st.lock_flag = lock_lvl & ~pll_wr;

    // Qualified needs lock and the filter; lost on any lock drop
    if (pll_wr || !st.lock_flag || !lock_lvl) begin
      next_st.osc_flag = 1'b0;
    end else if (filt_lvl) begin
      next_st.osc_flag = 1'b1;
    end
    osc_change = next_st.osc_flag ^ st.osc_flag;

    // Modulation: a pulse every sixteen reference ticks while enabled
    next_st.fm_tick = 1'b0;
    if (st.pll_cfg[`CUPT_PLL_MOD_HI:`CUPT_PLL_MOD_LO] == 2'b00) begin
      next_st.fm_div = 4'h0;
      next_st.fm_dir = 1'b0;
    end else if (ref_tick) begin
      if (st.fm_div == `CUPT_FM_DIV) begin
        next_st.fm_div  = 4'h0;
        next_st.fm_tick = 1'b1;
        next_st.fm_dir  = ~st.fm_dir;
      end else begin
        next_st.fm_div = st.fm_div + 4'h1;
      end
    end

    // Oscillator source only counts while the oscillator is qualified
    rti_src  = st.src_sel & st.osc_flag;
    next_st.rti_src_q = rti_src;
    rti_tick = rti_src ? osc_tick : ref_tick;
    rti_run  = !stop_lvl || (st.pseudo_stop_sel && rti_src);
    rti_restart = (wr_acc && (wr_addr == `CUPT_ADDR_RTI))
                  || (rti_src != st.rti_src_q);

    if (rti_restart || (rti_period(st.rti_ctrl) == 24'h00_0000)) begin
      next_st.rti_cnt = rti_period(next_st.rti_ctrl);
    end else if (rti_run && rti_tick) begin
      if (st.rti_cnt <= 24'h00_0001) begin
        rti_event       = 1'b1;
        next_st.rti_cnt = rti_period(st.rti_ctrl);
      end else begin
        next_st.rti_cnt = st.rti_cnt - 24'h00_0001;
      end
    end

    // Events; oscillator change counts only while enabled
    irq_set = {osc_change & st.osc_change_irq_en, api_timeout, rti_event};

    // Write-one clear, a set in the same cycle wins
    if (wr_acc && (wr_addr == `CUPT_ADDR_IRQ_CLR)) begin
      next_st.irq_stat = st.irq_stat & ~wr_byte[2:0];
    end
    next_st.irq_stat = next_st.irq_stat | irq_set;

    // Read data and error are prepared in setup for the access phase
    if (setup) begin
      next_st.prdata  = apb_i.pwrite ? 32'h0000_0000
                                     : read_word(apb_i.paddr, st);
      next_st.pslverr = ~addr_mapped(apb_i.paddr);
    end
  end

  // ========================================================================
  // Register the record
  // ========================================================================
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st          <= '0;
      st.pll_cfg  <= `CUPT_RST_BYTE;
      st.rti_ctrl <= `CUPT_RST_BYTE;
      st.irq_stat <= `CUPT_RST_IRQ;
      st.irq_en   <= `CUPT_RST_IRQ;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // Zero-wait slave: the answer stands in the first access cycle
  assign pready_o       = 1'b1;
  assign prdata_o       = st.prdata;
  assign pslverr_o      = st.pslverr & apb_i.psel & apb_i.penable;
  assign fm_amp_o       = st.pll_cfg[`CUPT_PLL_MOD_HI:`CUPT_PLL_MOD_LO];
  assign fm_rate_tick_o = st.fm_tick;
  assign fm_dir_o       = st.fm_dir;
  assign irq_o          = |(st.irq_stat & st.irq_en);

endmodule : cupt_clock_unit

// ==== verification/cupt_clock_unit_sva.sv ====
/* Port checker of cupt_clock_unit: bus answers, modulation outputs, interrupt mask.
   Assumes it is bound to the top module and sees only its ports. */
`include "cupt_regs.svh"
module cupt_clock_unit_sva
  import cupt_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  cupt_apb_req_t    apb_i,
  input  wire logic        pslverr_o,
  input  wire logic [31:0] prdata_o,
  input  wire logic [1:0]  fm_amp_o,
  input  wire logic        fm_rate_tick_o,
  input  wire logic        fm_dir_o,
  input  wire logic        irq_o
);
  // ==========================================================================
  // Helpers
  logic acc, setup, wr, mapped;  // Bus phases and address decode
  assign acc = apb_i.psel & apb_i.penable;
  assign setup = apb_i.psel & ~apb_i.penable;
  assign wr = acc & apb_i.pwrite;
  assign mapped = apb_i.paddr inside {`CUPT_ADDR_STATUS, `CUPT_ADDR_CLK_CTRL,
    `CUPT_ADDR_PLL_CFG, `CUPT_ADDR_RTI, `CUPT_ADDR_IRQ_STAT, `CUPT_ADDR_IRQ_CLR,
    `CUPT_ADDR_IRQ_EN, `CUPT_ADDR_API_CTRL, `CUPT_ADDR_API_RATE_H, `CUPT_ADDR_API_RATE_L};
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // ==========================================================================
  // Properties
  chk_err_phase: assert property (pslverr_o |-> acc) else $error("error outside access");
  chk_err_unmapped: assert property (acc && !mapped |-> pslverr_o) else $error("no error");
  chk_err_mapped: assert property (acc && mapped |-> !pslverr_o) else $error("false error");
  chk_rd_unmapped: assert property (setup && !apb_i.pwrite && !mapped |=> prdata_o == 0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (prdata_o[31:8] == 24'h00_0000) else $error("upper bits");
  chk_amp_write: assert property (wr && apb_i.paddr == `CUPT_ADDR_PLL_CFG
    |=> fm_amp_o == $past(apb_i.pwdata[5:4])) else $error("amplitude not taken");
  chk_tick_needs_fm: assert property (fm_rate_tick_o
    |-> fm_amp_o != 2'h0 || $past(fm_amp_o) != 2'h0) else $error("tick with modulation off");
  chk_tick_gap: assert property (fm_rate_tick_o |=> !fm_rate_tick_o [*8])
    else $error("rate ticks too close");
  chk_dir_off: assert property (fm_amp_o == 2'h0 && $past(fm_amp_o) == 2'h0 |-> !fm_dir_o)
    else $error("direction set while off");
  chk_irq_mask: assert property (wr && apb_i.paddr == `CUPT_ADDR_IRQ_EN
    && apb_i.pwdata[2:0] == 3'h0 |=> !irq_o) else $error("masked interrupt high");
endmodule : cupt_clock_unit_sva

// ==== verification/cupt_clock_unit_tb.sv ====
/* Self-checking bench of cupt_clock_unit driven over APB.
   Assumes the design, the checker and cupt_regs.svh are compiled first. */
`include "cupt_regs.svh"
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module cupt_clock_unit_tb
  import cupt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_sys_i = 1'h0, srst_i = 1'h1, filt = 1'h0, stp = 1'h0, err;
  cupt_apb_req_t apb = '0;
  logic [3:0]    ph = 4'h0;  // Pin divider: each level lasts at least two cycles
  logic          pready, pslverr, tick, dir, irq;
  logic [31:0]   prdata, rd;
  logic [1:0]    amp;
  int            num_errors = 0, n_compared = 0;
  time           t0, t1;
  initial forever #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) ph <= ph + 4'h1;
  cupt_clock_unit i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .apb_i(apb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .internal_ref_clk_i(ph[1]),
    .crystal_osc_clk_i(ph[2]), .aclk_i(ph[1]), .pll_lock_i(1'h1), .osc_filter_ok_i(filt),
    .stop_mode_i(stp), .fm_amp_o(amp), .fm_rate_tick_o(tick), .fm_dir_o(dir), .irq_o(irq));
  // ==========================================================================
  // Bus and wait tasks
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    apb.penable <= 1'h1;
    do @(posedge clk_sys_i); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'h0;
    apb.penable <= 1'h0;
    @(posedge clk_sys_i);
  endtask : xfer
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0000_0000);
    `CHECK(rd, e)
  endtask : rchk
  // Sampled on the falling edge so registered outputs have settled
  task automatic wait_ev(input logic sel, input int lim);
    int n;
    n = 0;
    do begin @(negedge clk_sys_i); n++; end while ((sel ? tick : irq) !== 1'h1 && n < lim);
    `CHECK(1'(n < lim), 1'h1)
    t1 = $time;
    @(posedge clk_sys_i);
  endtask : wait_ev
  // Rise to rise spacing of two aligned events, clearing between them
  task automatic gap(input logic sel, input logic [31:0] c, input int lim);
    wait_ev(sel, lim);
    xfer(1'h1, `CUPT_ADDR_IRQ_CLR, c);
    wait_ev(sel, lim);
    t0 = t1;
    xfer(1'h1, `CUPT_ADDR_IRQ_CLR, c);
    wait_ev(sel, lim);
  endtask : gap
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'h0;
    @(posedge clk_sys_i);
    rchk(`CUPT_ADDR_RTI, 32'h0000_0000);
    rchk(`CUPT_ADDR_API_RATE_L, 32'h0000_0000);
    xfer(1'h1, `CUPT_ADDR_RTI, 32'h0000_00A5);
    rchk(`CUPT_ADDR_RTI, 32'h0000_00A5);
    xfer(1'h1, 12'h3FC, 32'h0000_00FF);
    `CHECK(err, 1'h1)
    rchk(12'h3FC, 32'h0000_0000);
    // Periodic timer on the bus clock; rate writes while running are dropped
    xfer(1'h1, `CUPT_ADDR_API_RATE_L, 32'h0000_0003);
    xfer(1'h1, `CUPT_ADDR_API_CTRL, 32'h0000_0003);
    xfer(1'h1, `CUPT_ADDR_API_RATE_L, 32'h0000_0007);
    rchk(`CUPT_ADDR_API_RATE_L, 32'h0000_0003);
    xfer(1'h1, `CUPT_ADDR_IRQ_EN, 32'h0000_0002);
    gap(1'h0, 32'h0000_0002, 500);
    `CHECK(32'((t1 - t0) / 20), 32'h0000_0008)
    xfer(1'h1, `CUPT_ADDR_IRQ_EN, 32'h0000_0000);
    `CHECK(irq, 1'h0)
    // Oscillator status events with the enable set, then cleared
    xfer(1'h1, `CUPT_ADDR_CLK_CTRL, 32'h0000_0004);
    xfer(1'h1, `CUPT_ADDR_IRQ_EN, 32'h0000_0004);
    filt <= 1'h1;
    repeat (12) @(posedge clk_sys_i);
    `CHECK(irq, 1'h1)
    rchk(`CUPT_ADDR_STATUS, 32'h0000_0003);
    xfer(1'h1, `CUPT_ADDR_IRQ_CLR, 32'h0000_0004);
    for (int i = 0; i < 4; i++) begin
      xfer(1'h1, `CUPT_ADDR_PLL_CFG, 32'(i) << 4);
      `CHECK(amp, 2'(i))
    end
    repeat (12) @(posedge clk_sys_i);
    xfer(1'h0, `CUPT_ADDR_IRQ_STAT, 32'h0000_0000);
    `CHECK(rd[2], 1'h1)
    xfer(1'h1, `CUPT_ADDR_CLK_CTRL, 32'h0000_0001);
    repeat (12) @(posedge clk_sys_i);
    xfer(1'h1, `CUPT_ADDR_IRQ_CLR, 32'h0000_0004);
    xfer(1'h1, `CUPT_ADDR_PLL_CFG, 32'h0000_0030);
    repeat (12) @(posedge clk_sys_i);
    xfer(1'h0, `CUPT_ADDR_IRQ_STAT, 32'h0000_0000);
    `CHECK(rd[2], 1'h0)
    gap(1'h1, 32'h0000_0000, 200);
    `CHECK(32'((t1 - t0) / 20), 32'h0000_0040)
    // Periodic timer on the autonomous clock: 2*(1+1) ticks of 4 cycles
    xfer(1'h1, `CUPT_ADDR_API_CTRL, 32'h0000_0000);
    xfer(1'h1, `CUPT_ADDR_IRQ_CLR, 32'h0000_0002);
    xfer(1'h1, `CUPT_ADDR_API_RATE_L, 32'h0000_0001);
    xfer(1'h1, `CUPT_ADDR_API_CTRL, 32'h0000_0001);
    xfer(1'h1, `CUPT_ADDR_IRQ_EN, 32'h0000_0002);
    gap(1'h0, 32'h0000_0002, 500);
    `CHECK(32'((t1 - t0) / 20), 32'h0000_0010)
    // Timeout from the oscillator, rewritten midway: 1024 ticks of 8 cycles
    xfer(1'h1, `CUPT_ADDR_IRQ_EN, 32'h0000_0001);
    xfer(1'h1, `CUPT_ADDR_RTI, 32'h0000_0010);
    repeat (3000) @(posedge clk_sys_i);
    xfer(1'h1, `CUPT_ADDR_IRQ_CLR, 32'h0000_0001);
    xfer(1'h1, `CUPT_ADDR_RTI, 32'h0000_0010);
    t0 = $time;
    wait_ev(1'h0, 9000);
    `CHECK(1'((t1 - t0) / 20 > 8180 && (t1 - t0) / 20 < 8210), 1'h1)
    // Source change restarts: 1024 reference ticks of 4 cycles
    repeat (3000) @(posedge clk_sys_i);
    xfer(1'h1, `CUPT_ADDR_IRQ_CLR, 32'h0000_0001);
    xfer(1'h1, `CUPT_ADDR_CLK_CTRL, 32'h0000_0000);
    t0 = $time;
    wait_ev(1'h0, 9000);
    `CHECK(1'((t1 - t0) / 20 > 4080 && (t1 - t0) / 20 < 4110), 1'h1)
    // Stop halts the reference count; pseudo-stop runs the oscillator one
    stp <= 1'h1;
    xfer(1'h1, `CUPT_ADDR_CLK_CTRL, 32'h0000_0002);
    xfer(1'h1, `CUPT_ADDR_IRQ_CLR, 32'h0000_0001);
    repeat (5000) @(posedge clk_sys_i);
    `CHECK(irq, 1'h0)
    xfer(1'h1, `CUPT_ADDR_CLK_CTRL, 32'h0000_0003);
    wait_ev(1'h0, 9000);
    summarize();
  end
  // Hang guard, well beyond the longest path of the scenarios
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    num_errors++;
    summarize();
  end
endmodule : cupt_clock_unit_tb
bind cupt_clock_unit cupt_clock_unit_sva i_sva (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
  .apb_i(apb_i), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .fm_amp_o(fm_amp_o),
  .fm_rate_tick_o(fm_rate_tick_o), .fm_dir_o(fm_dir_o), .irq_o(irq_o));
